// file: hw/pixel_bus_multiplexer.sv
// Purpose: Pixel port multiplexer turning bus loads into palette addresses
// Assumes: bus_load_clock and dot_rate_clock are synchronous level inputs
// Notes: True-colour formats are not handled here; their codes are ignored
// Summary of operation
// - An 8-bit configuration register selects operating mode and pixel bus width.
// - Configuration bits 7 and 6 are ignored; bits 5:0 pick the mode.
// - Value 2Dh selects VGA pass-through, eight bits per pixel, same as reset.
// - Value 1Eh: mode 4, 32-bit bus, four pixels, byte 0 shown first.
// - Pixels per bus load equal the bus-load divide ratio.
// - Each bus-load clock rising edge while the buffer has room latches every group of the load at once.
// - Groups leave one per dot clock, lowest-numbered group first.
// - Mode 1: 0100 plus width code, one bit per pixel, bit 0 first.
// - Mode 2: 0101 plus width code, two bits per pixel, bits 1:0 first.
// - Mode 3: 0110 plus width code, four bits per pixel, bits 3:0 first.
// - Mode 4: codes 011100 to 011110, eight bits per pixel, 8/16/32 bus.
// - Mode 5: code 011111, nibble flag picks low or high nibble of each byte.
// - Latched bits act as palette address bits in modes 0 to 5.
// - Mode 1 pixel bit drives address bit 0; page register gives upper seven.
// - Special-nibble enable overrides the configuration register setting while the split bit is clear.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pixel_bus_multiplexer #(
	parameter int unsigned FIFO_DEPTH = pixmux_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [pixmux_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	input wire logic bus_load_clock,
	input wire logic dot_rate_clock,
	input wire logic nibble_select_flag,
	input wire logic [pixmux_pkg::PIXEL_BUS_W-1:0] pixel_bus,
	input wire logic [7:0] vga_pixel,
	output logic load_ready_q,
	output logic [7:0] palette_addr_q,
	output logic palette_addr_valid_q
);
	localparam int unsigned PBW = pixmux_pkg::PIXEL_BUS_W;
	localparam int unsigned WORD_W = pixmux_pkg::FMT_W + PBW;

	// Decode bits 5:0 into a format; returns valid low for unused codes
	function automatic logic decode_cfg(input logic [5:0] code, output pixmux_pkg::pix_fmt_t f);
		logic [1:0] ww;
		ww = code[1:0];
		f = pixmux_pkg::FMT_RESET;
		decode_cfg = 1'b1;
		if (code == pixmux_pkg::CODE_VGA) begin
			f = pixmux_pkg::FMT_RESET;
		end else if (code == pixmux_pkg::CODE_MODE5) begin
			f = pixmux_pkg::FMT_NIBBLE;
		end else if (code[5:2] == pixmux_pkg::PFX_MODE1) begin
			f = '{mode: pixmux_pkg::MODE_1, bpp_log: 2'h0, grp_log: 3'(ww) + 3'h2};
		end else if (code[5:2] == pixmux_pkg::PFX_MODE2) begin
			f = '{mode: pixmux_pkg::MODE_2, bpp_log: 2'h1, grp_log: 3'(ww) + 3'h1};
		end else if (code[5:2] == pixmux_pkg::PFX_MODE3) begin
			f = '{mode: pixmux_pkg::MODE_3, bpp_log: 2'h2, grp_log: 3'(ww)};
		end else if (code[5:2] == pixmux_pkg::PFX_MODE4 && ww <= pixmux_pkg::MODE4_MAX_WIDTH) begin
			f = '{mode: pixmux_pkg::MODE_4, bpp_log: 2'h3, grp_log: 3'(ww)};
		end else begin
			decode_cfg = 1'b0;
		end
	endfunction

	// Register file state
	logic [7:0] cfg_q, cfg_d, gctrl_q, gctrl_d, page_q, page_d, rdata_d;
	pixmux_pkg::pix_fmt_t fmt_q, fmt_d, fmt_new, fmt_live;
	logic overrun_q, overrun_d, cfg_ok;

	// Pin sampling state
	logic load_prev_q, dot_prev_q, load_edge, dot_edge, ready_d;

	// Shifter state
	logic [PBW-1:0] shift_q, shift_d;
	pixmux_pkg::pix_fmt_t sfmt_q, sfmt_d;
	logic [5:0] rem_q, rem_d;
	logic [7:0] addr_d;
	logic avalid_d;

	// Capture word
	logic [PBW-1:0] cap_word;

	stream_if #(.W(WORD_W)) push_s ();
	stream_if #(.W(WORD_W)) pop_s ();

	pixel_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.in_s(push_s),
		.out_s(pop_s)
	);

	// Edge detect on the sampled clock pins
	always_comb begin
		load_edge = bus_load_clock && !load_prev_q;
		dot_edge = dot_rate_clock && !dot_prev_q;
	end

	// Register writes, reads and the active format
	always_comb begin
		// Live format first, so the status read below sees this cycle's value
		if (gctrl_q[pixmux_pkg::GC_NIBBLE_EN_BIT] && !gctrl_q[pixmux_pkg::GC_SPLIT_BIT]) begin
			fmt_live = pixmux_pkg::FMT_NIBBLE;
		end else begin
			fmt_live = fmt_q;
		end
		cfg_d = cfg_q;
		gctrl_d = gctrl_q;
		page_d = page_q;
		fmt_d = fmt_q;
		overrun_d = overrun_q;
		rdata_d = reg_rdata_q;
		cfg_ok = decode_cfg(reg_wdata[5:0], fmt_new);
		if (reg_wr) begin
			unique case (reg_addr)
				pixmux_pkg::ADDR_MUX_CFG: begin
					cfg_d = reg_wdata;
					if (cfg_ok) begin
						fmt_d = fmt_new;
					end
				end
				pixmux_pkg::ADDR_GEN_CTRL: gctrl_d = reg_wdata;
				pixmux_pkg::ADDR_PAGE: page_d = reg_wdata;
				pixmux_pkg::ADDR_STATUS: begin
					if (reg_wdata[pixmux_pkg::ST_OVERRUN_BIT]) begin
						overrun_d = 1'b0;
					end
				end
			endcase
		end
		// A lost load in the clearing cycle still sets the flag
		if (load_edge && !push_s.ready) begin
			overrun_d = 1'b1;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				pixmux_pkg::ADDR_MUX_CFG: rdata_d = cfg_q;
				pixmux_pkg::ADDR_GEN_CTRL: rdata_d = gctrl_q;
				pixmux_pkg::ADDR_PAGE: rdata_d = page_q;
				pixmux_pkg::ADDR_STATUS: begin
					rdata_d = 8'h00;
					rdata_d[2:0] = fmt_live.mode;
					rdata_d[pixmux_pkg::ST_OVERRUN_BIT] = overrun_q;
					rdata_d[pixmux_pkg::ST_EMPTY_BIT] = !pop_s.valid && rem_q == '0;
				end
			endcase
		end
	end

	// Capture one whole load per bus-load edge; format travels with it
	always_comb begin
		cap_word = pixel_bus;
		if (fmt_live.mode == pixmux_pkg::MODE_VGA) begin
			cap_word = PBW'(vga_pixel);
		end else if (fmt_live.mode == pixmux_pkg::MODE_5) begin
			cap_word = '0;
			for (int i = 0; i < 4; i++) begin
				cap_word[4*i +: 4] = nibble_select_flag ? pixel_bus[8*i+4 +: 4]
					: pixel_bus[8*i +: 4];
			end
		end
		push_s.valid = load_edge;
		push_s.data = {fmt_live, cap_word};
		ready_d = push_s.ready;
	end

	// One group per dot edge, low group first; the divide ratio is not
	// derived here, software must match the bus-load rate to the group count
	always_comb begin
		logic [3:0] bits;
		logic [7:0] low;
		logic [PBW-1:0] src;
		pixmux_pkg::pix_fmt_t f;
		bits = 4'h0;
		low = 8'h00;
		src = shift_q;
		f = sfmt_q;
		shift_d = shift_q;
		sfmt_d = sfmt_q;
		rem_d = rem_q;
		addr_d = palette_addr_q;
		avalid_d = 1'b0;
		pop_s.ready = dot_edge && rem_q == '0;
		if (dot_edge && (rem_q != '0 || pop_s.valid)) begin
			if (rem_q == '0) begin
				{f, src} = pop_s.data;
				sfmt_d = f;
				rem_d = 6'((7'h01 << f.grp_log) - 7'h01);
			end else begin
				rem_d = rem_q - 6'h01;
			end
			bits = 4'h1 << f.bpp_log;
			low = ~(8'hff << bits);
			addr_d = (page_q & ~low) | (src[7:0] & low);
			shift_d = src >> bits;
			avalid_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_q <= pixmux_pkg::MUX_CFG_RESET;
			gctrl_q <= pixmux_pkg::GEN_CTRL_RESET;
			page_q <= pixmux_pkg::PAGE_RESET;
			fmt_q <= pixmux_pkg::FMT_RESET;
			overrun_q <= 1'b0;
			reg_rdata_q <= 8'h00;
			load_prev_q <= 1'b0;
			dot_prev_q <= 1'b0;
			load_ready_q <= 1'b0;
			shift_q <= '0;
			sfmt_q <= pixmux_pkg::FMT_RESET;
			rem_q <= '0;
			palette_addr_q <= 8'h00;
			palette_addr_valid_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			gctrl_q <= gctrl_d;
			page_q <= page_d;
			fmt_q <= fmt_d;
			overrun_q <= overrun_d;
			reg_rdata_q <= rdata_d;
			load_prev_q <= bus_load_clock;
			dot_prev_q <= dot_rate_clock;
			load_ready_q <= ready_d;
			shift_q <= shift_d;
			sfmt_q <= sfmt_d;
			rem_q <= rem_d;
			palette_addr_q <= addr_d;
			palette_addr_valid_q <= avalid_d;
		end
	end
endmodule
`default_nettype wire

// file: hw/pixel_fifo.sv
// Purpose: Word buffer between bus-load capture and pixel shifting
// Assumes: Synchronous active-high reset on sys_clk
// Notes: Output word sits in a register, so capacity is DEPTH plus one
`timescale 1ns/1ns
`default_nettype none
module pixel_fifo #(
	parameter int unsigned W = 40,
	parameter int unsigned DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	stream_if.dst in_s,
	stream_if.src out_s
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] count_q, count_d;
	logic [W-1:0] odata_q, odata_d;
	logic oval_q, oval_d;
	logic push, load_out;

	// Pointer, level and output stage next values
	always_comb begin
		// Level is PW+1 bits wide so a full array of DEPTH words is representable
		push = in_s.valid && (count_q != (PW+1)'(DEPTH));
		load_out = (count_q != '0) && (!oval_q || out_s.ready);
		wr_d = push ? wr_q + PW'(1) : wr_q;
		rd_d = load_out ? rd_q + PW'(1) : rd_q;
		count_d = count_q + (push ? (PW+1)'(1) : '0) - (load_out ? (PW+1)'(1) : '0);
		odata_d = load_out ? mem[rd_q] : odata_q;
		oval_d = load_out ? 1'b1 : (out_s.ready ? 1'b0 : oval_q);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			odata_q <= '0;
			oval_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			count_q <= count_d;
			odata_q <= odata_d;
			oval_q <= oval_d;
		end
	end

	// Storage array, no reset needed since reads follow writes
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_q] <= in_s.data;
		end
	end

	// Full is honest: ready drops as soon as the array holds DEPTH words
	assign in_s.ready = (count_q != (PW+1)'(DEPTH));
	assign out_s.data = odata_q;
	assign out_s.valid = oval_q;
endmodule
`default_nettype wire

// file: hw/pixmux_pkg.sv
// Purpose: Shared constants and types of the pixel bus multiplexer
// Assumes: Single sys_clk domain, plain register port with 2-bit word address
// Notes: Offsets are word indices on the plain register port
package pixmux_pkg;

	// Register port geometry and offsets
	localparam int unsigned REG_ADDR_W = 2;
	localparam logic [1:0] ADDR_MUX_CFG = 2'h0;
	localparam logic [1:0] ADDR_GEN_CTRL = 2'h1;
	localparam logic [1:0] ADDR_PAGE = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;

	// Values after reset
	localparam logic [7:0] MUX_CFG_RESET = 8'h2d;
	localparam logic [7:0] GEN_CTRL_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;

	// Field positions
	localparam int unsigned GC_NIBBLE_EN_BIT = 3;
	localparam int unsigned GC_SPLIT_BIT = 2;
	localparam int unsigned ST_OVERRUN_BIT = 4;
	localparam int unsigned ST_EMPTY_BIT = 5;

	// Mode selection codes on configuration bits 5:0
	localparam logic [5:0] CODE_VGA = 6'h2d;
	localparam logic [3:0] PFX_MODE1 = 4'h4;
	localparam logic [3:0] PFX_MODE2 = 4'h5;
	localparam logic [3:0] PFX_MODE3 = 4'h6;
	localparam logic [3:0] PFX_MODE4 = 4'h7;
	localparam logic [1:0] MODE4_MAX_WIDTH = 2'h2;
	localparam logic [5:0] CODE_MODE5 = 6'h1f;

	// Pixel port geometry and buffering
	localparam int unsigned PIXEL_BUS_W = 32;
	localparam int unsigned FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		MODE_VGA,
		MODE_1,
		MODE_2,
		MODE_3,
		MODE_4,
		MODE_5
	} pix_mode_t;

	// Active format: bits per pixel and groups per load as powers of two
	typedef struct packed {
		pix_mode_t mode;
		logic [1:0] bpp_log;
		logic [2:0] grp_log;
	} pix_fmt_t;

	localparam int unsigned FMT_W = $bits(pix_fmt_t);
	localparam pix_fmt_t FMT_RESET = '{mode: MODE_VGA, bpp_log: 2'h3, grp_log: 3'h0};
	localparam pix_fmt_t FMT_NIBBLE = '{mode: MODE_5, bpp_log: 2'h2, grp_log: 3'h2};

endpackage

// file: hw/stream_if.sv
// Purpose: Valid/ready word stream between the multiplexer and its buffer
// Assumes: Both ends run on the same clock
// Notes: A word moves in a cycle where valid and ready are both high
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(
	parameter int unsigned W = 8
);
	logic [W-1:0] data;
	logic valid;
	logic ready;

	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: verification/pixel_bus_multiplexer_tb_top.sv
// Purpose: Self-checking bench for pixel_bus_multiplexer
// Assumes: Model drives the pixel port, bench drives registers
// Notes: Codes 10h to 1Fh are all swept through status
`timescale 1ns/1ns
`default_nettype none
module pixel_bus_multiplexer_tb_top;
	logic sys_clk, srst, reg_wr, reg_rd, start, do_load, nib, busy, load_ready_q;
	logic bus_load_clock, dot_rate_clock, nibble_select_flag, palette_addr_valid_q;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_q, palette_addr_q, vga_pixel, pg;
	logic [31:0] word, pixel_bus;
	logic [5:0] dots;
	logic [7:0] got[$];
	int err_count = 0;
	int samples_checked = 0;
	int cf[6] = '{8'h1e, 8'h1a, 8'h10, 8'h13, 8'h17, 8'h19};
	int bp[6] = '{8, 4, 1, 1, 2, 4};
	int gn[6] = '{4, 4, 4, 32, 16, 2};
	pixel_bus_multiplexer pixel_bus_multiplexer_inst (.sys_clk(sys_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .bus_load_clock(bus_load_clock),
		.dot_rate_clock(dot_rate_clock), .nibble_select_flag(nibble_select_flag),
		.pixel_bus(pixel_bus), .vga_pixel(vga_pixel), .load_ready_q(load_ready_q),
		.palette_addr_q(palette_addr_q), .palette_addr_valid_q(palette_addr_valid_q));
	pixel_source_model pixel_source_model_inst (.sys_clk(sys_clk), .start(start),
		.do_load(do_load), .word(word), .nib(nib), .dots(dots), .busy(busy),
		.bus_load_clock(bus_load_clock), .dot_rate_clock(dot_rate_clock),
		.pixel_bus(pixel_bus), .vga_pixel(vga_pixel), .nibble_select_flag(nibble_select_flag));
	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Collect every emitted palette address
	always @(posedge sys_clk) if (palette_addr_valid_q === 1'b1) got.push_back(palette_addr_q);
	task automatic wrap_up();
		$display("Compared %0d, mismatched %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [7:0] act, input logic [7:0] exp);
		samples_checked++;
		if (act !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
		end
	endtask
	// Extra edge after the strobe so back-to-back calls never reassign it
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		check(reg_rdata_q, e);
	endtask
	task automatic run(input logic ld, input logic [31:0] w, input int n, input logic nb);
		int to;
		do_load <= ld;
		word <= w;
		nib <= nb;
		dots <= 6'(n);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (2) @(posedge sys_clk);
		to = 400;
		while (busy !== 1'b0 && to > 0) begin
			@(posedge sys_clk);
			to--;
		end
		if (to == 0) begin
			err_count++;
			wrap_up();
		end
	endtask
	// Group g sits at bit g*st; low bits from pixel, the rest from page
	task automatic expect_px(input logic [31:0] w, input int bpp, input int st, input int n);
		logic [7:0] m;
		m = 8'((1 << bpp) - 1);
		check(8'(got.size()), 8'(n));
		for (int g = 0; g < n && got.size() > 0; g++)
			check(got.pop_front(), (pg & ~m) | (8'(w >> (g * st)) & m));
		got.delete();
	endtask
	initial begin
		int em;
		srst = 1'b1;
		{reg_wr, reg_rd, start, nib, do_load} = 5'h00;
		{reg_addr, reg_wdata, word, dots, pg} = '0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(2'h0, 8'h2d);
		rd(2'h3, 8'h20);
		run(1'b1, 32'h1234_5678, 1, 1'b0);
		expect_px(32'h0012_3456, 8, 8, 1);
		for (int c = 8'h10; c < 8'h20; c++) begin
			em = (c == 8'h1f) ? 5 : (c >= 8'h1c) ? 4 : (c >> 2) - 3;
			wr(2'h0, 8'(c) | 8'hc0);
			rd(2'h3, 8'h20 | 8'(em));
		end
		wr(2'h0, 8'h28);
		rd(2'h0, 8'h28);
		rd(2'h3, 8'h25);
		wr(2'h2, 8'h5a);
		pg = 8'h5a;
		rd(2'h2, 8'h5a);
		foreach (cf[i]) begin
			wr(2'h0, 8'(cf[i]));
			run(1'b1, 32'hc3a5_9617, gn[i], 1'b0);
			expect_px(32'hc3a5_9617, bp[i], bp[i], gn[i]);
		end
		wr(2'h0, 8'h1f);
		run(1'b1, 32'h9c3a_e571, 4, 1'b1);
		expect_px(32'h09c3_ae57, 4, 8, 4);
		wr(2'h1, 8'h0c);
		wr(2'h0, 8'h1e);
		rd(2'h3, 8'h24);
		wr(2'h1, 8'h08);
		rd(2'h1, 8'h08);
		run(1'b1, 32'h9c3a_e571, 4, 1'b0);
		expect_px(32'h9c3a_e571, 4, 8, 4);
		wr(2'h1, 8'h00);
		wr(2'h0, 8'h1c);
		for (int i = 0; i < 19; i++) run(1'b1, 32'(i), 0, 1'b0);
		check(8'(load_ready_q), 8'h00);
		rd(2'h3, 8'h14);
		run(1'b0, 32'h0000_0000, 17, 1'b0);
		check(8'(got.size()), 8'h11);
		for (int i = 0; i < 17 && got.size() > 0; i++) check(got.pop_front(), 8'(i));
		rd(2'h3, 8'h34);
		wr(2'h3, 8'h10);
		rd(2'h3, 8'h24);
		wrap_up();
	end
endmodule
`default_nettype wire

// file: verification/pixel_source_model.sv
// Purpose: Graphics controller driving one bus load and dot edges
// Assumes: Clocks are levels changed just after sys_clk edges
// Notes: Pixel lines show inverted data once hold time is over
`timescale 1ns/1ns
`default_nettype none
module pixel_source_model (
	input wire logic sys_clk,
	input wire logic start,
	input wire logic do_load,
	input wire logic [31:0] word,
	input wire logic nib,
	input wire logic [5:0] dots,
	output logic busy,
	output logic bus_load_clock,
	output logic dot_rate_clock,
	output logic [31:0] pixel_bus,
	output logic [7:0] vga_pixel,
	output logic nibble_select_flag
);
	// One optional load, then a burst of dot edges four cycles apart
	initial begin
		busy = 1'b0;
		bus_load_clock = 1'b0;
		dot_rate_clock = 1'b0;
		pixel_bus = 32'h0000_0000;
		vga_pixel = 8'h00;
		nibble_select_flag = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (start) begin
				busy <= 1'b1;
				if (do_load) begin
					pixel_bus <= word;
					vga_pixel <= word[15:8];
					nibble_select_flag <= nib;
					@(posedge sys_clk);
					bus_load_clock <= 1'b1;
					@(posedge sys_clk);
					pixel_bus <= ~word;
					vga_pixel <= ~word[15:8];
					repeat (2) @(posedge sys_clk);
					bus_load_clock <= 1'b0;
					repeat (2) @(posedge sys_clk);
				end
				repeat (dots) begin
					dot_rate_clock <= 1'b1;
					repeat (2) @(posedge sys_clk);
					dot_rate_clock <= 1'b0;
					repeat (2) @(posedge sys_clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/pixmux_props.sv
// Purpose: Port checks for pixel_bus_multiplexer
// Assumes: One clock domain, srst synchronous
// Notes: Shadow copies follow software register writes
`timescale 1ns/1ns
`default_nettype none
module pixmux_props #(
	parameter int unsigned FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic dot_rate_clock,
	input wire logic [7:0] palette_addr_q,
	input wire logic palette_addr_valid_q
);
	logic [7:0] cfg_q, gc_q, pg_q;
	logic [2:0] mode_q, mode_d, live;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Decode on bits 5:0 only; unlisted codes keep the old mode
	always_comb begin
		mode_d = mode_q;
		if (reg_wr && reg_addr == 2'h0 && reg_wdata[5:0] == 6'h2d)
			mode_d = 3'h0;
		else if (reg_wr && reg_addr == 2'h0 && reg_wdata[5:4] == 2'h1)
			mode_d = (reg_wdata[3:0] == 4'hf) ? 3'h5 : {1'b0, reg_wdata[3:2]} + 3'h1;
	end
	// Nibble enable wins over the configuration code unless the split bit is set
	assign live = (gc_q[3] && !gc_q[2]) ? 3'h5 : mode_q;
	// Shadow registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_q <= 8'h2d;
			gc_q <= 8'h00;
			pg_q <= 8'h00;
			mode_q <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == 2'h0) cfg_q <= reg_wdata;
			if (reg_wr && reg_addr == 2'h1) gc_q <= reg_wdata;
			if (reg_wr && reg_addr == 2'h2) pg_q <= reg_wdata;
			mode_q <= mode_d;
		end
	end
	chk_cfg_readback: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata_q == $past(cfg_q))
		else $error("config readback wrong");
	chk_ctrl_readback: assert property (reg_rd && reg_addr == 2'h1 |=> reg_rdata_q == $past(gc_q))
		else $error("control readback wrong");
	chk_page_readback: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata_q == $past(pg_q))
		else $error("page readback wrong");
	chk_live_mode: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata_q[2:0] == $past(live))
		else $error("live mode wrong");
	chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved without read");
	chk_valid_pulse: assert property (palette_addr_valid_q |=> !palette_addr_valid_q)
		else $error("pixel valid longer than one cycle");
	chk_valid_on_dot: assert property (palette_addr_valid_q |-> $past(dot_rate_clock) && !$past(dot_rate_clock, 2))
		else $error("pixel without dot edge");
	chk_addr_holds: assert property (!palette_addr_valid_q |-> $stable(palette_addr_q))
		else $error("address moved without pixel");
endmodule
bind pixel_bus_multiplexer pixmux_props #(.FIFO_DEPTH(FIFO_DEPTH)) pixmux_props_inst (
	.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.dot_rate_clock(dot_rate_clock), .palette_addr_q(palette_addr_q),
	.palette_addr_valid_q(palette_addr_valid_q));
`default_nettype wire
